// ---- dv/test_two_wire_bus_master_slave_ctrl.sv ----
module test_two_wire_bus_master_slave_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // signals
  logic        clk, rst, wbCyc, wbStb, wbWe;
  logic [7:0]  wbAdr, rxByte, q, b8;
  logic        sclM, sdaM, ak;
  logic [3:0]  wbSel;
  logic [31:0] wbDatW, wbDatR;
  logic        wbAck, sclOe, sdaOe, sdaOeM, irq, scl, sda, mNack;
  int          fail_count, check_count, cycN;
  // open drain with pull-ups
  assign scl = !(sclOe || sclM);
  assign sda = !(sdaOe || sdaOeM || sdaM);
  tw_ctrl tw_ctrl_i (.clk, .rst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel,
    .wbDatW, .wbDatR, .wbAck, .sclI(scl), .sclO(), .sclOe, .sdaI(sda),
    .sdaO(), .sdaOe, .irq);
  tw_slave_model tw_slave_model_i (.scl, .sda, .sdaOe(sdaOeM), .rxByte,
    .mNack);
  initial begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  // ==========
  // tasks
  task automatic report_and_stop;
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // timeout: four bytes of ~4600 cycles plus polling
  always @(posedge clk) begin
    cycN <= cycN + 1;
    if (cycN == 60000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatW <= {24'h0, d};
    do @(posedge clk); while (wbAck !== 1'b1);
    q = wbDatR[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk(q, exp);
  endtask : rd
  task automatic waitStat(input int n, input logic v);
    for (int i = 0; i < 4000; i++) begin
      wb(1'b0, tw_pkg::ADR_STAT, 8'h00);
      if (q[n] === v) break;
    end
  endtask : waitStat
  task automatic waitScl;
    for (int i = 0; i < 1000; i++) begin
      @(posedge clk);
      if (sclOe === 1'b1) break;
    end
  endtask : waitScl
  // bench as second master: eight clocks a bit, waits out stretching
  task automatic mBit(input logic b, output logic s);
    sdaM <= !b;
    repeat (3) @(posedge clk);
    sclM <= 1'b0;
    do @(posedge clk); while (scl !== 1'b1);
    repeat (3) @(posedge clk);
    s = sda;
    sclM <= 1'b1;
    @(posedge clk);
  endtask : mBit
  task automatic mByte(input logic [7:0] d, output logic [7:0] got,
                       output logic k);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      mBit(d[i], s);
      got = {got[6:0], s};
    end
    mBit(1'b1, k);
  endtask : mByte
  task automatic mStart;
    sdaM <= 1'b1;
    repeat (4) @(posedge clk);
    sclM <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : mStart
  task automatic mStop;
    sdaM <= 1'b1;
    repeat (3) @(posedge clk);
    sclM <= 1'b0;
    do @(posedge clk); while (scl !== 1'b1);
    repeat (3) @(posedge clk);
    sdaM <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : mStop
  // ==========
  // sequence
  initial begin
    {rst, wbCyc, wbStb, wbWe, wbAdr, wbDatW} = {1'b1, 43'h0};
    wbSel = 4'h1;
    {sclM, sdaM} = 2'b00;
    {fail_count, check_count, cycN} = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(tw_pkg::ADR_CTRL, 8'h00);
    rd(tw_pkg::ADR_STAT, 8'h00);
    rd(8'h14, 8'h00);
    wb(1'b1, tw_pkg::ADR_CTRL, 8'h84);
    rd(tw_pkg::ADR_STAT, 8'h12);
    rd(tw_pkg::ADR_CTRL, 8'h80);
    chk({7'h0, irq}, 8'h00);
    wb(1'b1, tw_pkg::ADR_STAT, 8'h12);
    rd(tw_pkg::ADR_STAT, 8'h00);
    wb(1'b1, tw_pkg::ADR_CTRL, 8'hd0);
    wb(1'b1, tw_pkg::ADR_CTRL, 8'hf0);
    waitScl();
    rd(tw_pkg::ADR_STAT, 8'h20);
    wb(1'b1, tw_pkg::ADR_DATA, 8'ha0);
    waitStat(tw_pkg::S_TC, 1'b1);
    rd(tw_pkg::ADR_STAT, 8'ha2);
    chk({7'h0, irq}, 8'h01);
    wb(1'b1, tw_pkg::ADR_DATA, 8'h3c);
    rd(tw_pkg::ADR_STAT, 8'h22);
    waitStat(tw_pkg::S_TC, 1'b1);
    chk(rxByte, 8'h3c);
    wb(1'b1, tw_pkg::ADR_STAT, 8'h02);
    chk({7'h0, irq}, 8'h00);
    wb(1'b1, tw_pkg::ADR_CTRL, 8'hd0);
    waitStat(tw_pkg::S_BY, 1'b0);
    chk(q & 8'h20, 8'h00);
    wb(1'b1, tw_pkg::ADR_CTRL, 8'hf0);
    waitScl();
    wb(1'b1, tw_pkg::ADR_DATA, 8'ha1);
    waitStat(tw_pkg::S_TC, 1'b1);
    chk(q & 8'h01, 8'h00);
    wb(1'b1, tw_pkg::ADR_CTRL, 8'he8);
    wb(1'b0, tw_pkg::ADR_DATA, 8'h00);
    waitStat(tw_pkg::S_TC, 1'b1);
    // leave master before the read so no further byte starts
    wb(1'b1, tw_pkg::ADR_CTRL, 8'hc8);
    waitStat(tw_pkg::S_BY, 1'b0);
    rd(tw_pkg::ADR_DATA, 8'h96);
    chk({7'h0, mNack}, 8'h01);
    wb(1'b1, tw_pkg::ADR_CTRL, 8'hf0);
    waitScl();
    rd(tw_pkg::ADR_DATA, 8'h96);
    repeat (300) @(posedge clk);
    chk({6'h0, sclOe, sdaOe}, 8'h03);
    wb(1'b1, tw_pkg::ADR_CTRL, 8'hd0);
    waitStat(tw_pkg::S_BY, 1'b0);
    // bench as second master: device addressed as slave transmitter
    wb(1'b1, tw_pkg::ADR_STAT, 8'h02);
    wb(1'b1, tw_pkg::ADR_SADR, 8'h54);
    mStart();
    mByte(8'h55, b8, ak);
    chk({7'h0, ak}, 8'h00);
    rd(tw_pkg::ADR_STAT, 8'he6);
    wb(1'b1, tw_pkg::ADR_CTRL, 8'h90);
    rd(tw_pkg::ADR_STAT, 8'ha6);
    wb(1'b1, tw_pkg::ADR_DATA, 8'hc5);
    mByte(8'hff, b8, ak);
    chk(b8, 8'hc5);
    mStop();
    rd(tw_pkg::ADR_STAT, 8'h87);
    // general call, then a data read lets the stretched clock go
    wb(1'b1, tw_pkg::ADR_STAT, 8'h02);
    wb(1'b1, tw_pkg::ADR_CTRL2, 8'h80);
    wb(1'b1, tw_pkg::ADR_CTRL, 8'h80);
    mStart();
    mByte(8'h00, b8, ak);
    chk({7'h0, ak}, 8'h00);
    rd(tw_pkg::ADR_STAT, 8'he3);
    rd(tw_pkg::ADR_DATA, 8'h96);
    mStop();
    rd(tw_pkg::ADR_STAT, 8'h43);
    wb(1'b1, tw_pkg::ADR_CTRL, 8'h20);
    repeat (300) @(posedge clk);
    chk({6'h0, sclOe, sdaOe}, 8'h00);
    report_and_stop();
  end
endmodule : test_two_wire_bus_master_slave_ctrl

// ---- dv/tw_ctrl_properties.sv ----
module tw_ctrl_properties (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // wishbone slave
  input wire logic        wbCyc,
  input wire logic        wbStb,
  input wire logic        wbWe,
  input wire logic [7:0]  wbAdr,
  input wire logic [3:0]  wbSel,
  input wire logic [31:0] wbDatW,
  input wire logic [31:0] wbDatR,
  input wire logic        wbAck,
  // two-wire pins
  input wire logic        sclI,
  input wire logic        sclO,
  input wire logic        sclOe,
  input wire logic        sdaI,
  input wire logic        sdaO,
  input wire logic        sdaOe,
  // interrupt
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========
  // helpers
  logic take;
  logic ctlW;
  logic msSh_r;
  assign take = wbCyc && wbStb && !wbAck;
  assign ctlW = take && wbWe && wbSel[0] && wbAdr == tw_pkg::ADR_CTRL;
  // en low clears master select too, so shadow follows both bits
  always_ff @(posedge clk) begin
    if (rst) msSh_r <= 1'b0;
    else if (ctlW) msSh_r <= wbDatW[tw_pkg::C_MS] & wbDatW[tw_pkg::C_EN];
  end
  // ==========
  // bus handshake
  property p_ack_next;
    take |=> wbAck;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing after request");
  property p_ack_pulse;
    wbAck |=> !wbAck;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_rd_high;
    wbAck && !wbWe |-> wbDatR[31:8] == 24'h0;
  endproperty
  a_rd_high: assert property (p_rd_high)
    else $error("upper read data not zero");
  property p_od;
    !sclO && !sdaO;
  endproperty
  a_od: assert property (p_od)
    else $error("pin driven high");
  // ==========
  // control behaviour
  property p_reset;
    $past(rst) |-> !wbAck && !sclOe && !sdaOe && !irq;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs active after reset");
  property p_rs_zero;
    wbAck && !wbWe && wbAdr == tw_pkg::ADR_CTRL |-> !wbDatR[tw_pkg::C_RS];
  endproperty
  a_rs_zero: assert property (p_rs_zero)
    else $error("repeat start bit read as one");
  property p_ie_mask;
    ctlW && !wbDatW[tw_pkg::C_IE] |=> ##1 !irq;
  endproperty
  a_ie_mask: assert property (p_ie_mask)
    else $error("irq with interrupt enable low");
  property p_dis;
    ctlW && !wbDatW[tw_pkg::C_EN] |=> (!sclOe && !sdaOe)[*8];
  endproperty
  a_dis: assert property (p_dis)
    else $error("lines driven while disabled");
  property p_start;
    ctlW && wbDatW[tw_pkg::C_EN] && wbDatW[tw_pkg::C_MS] && !msSh_r
      && sclI && sdaI |-> ##[1:300] (sdaOe && !sclOe);
  endproperty
  a_start: assert property (p_start)
    else $error("no start after master select");
  property p_stop;
    ctlW && wbDatW[tw_pkg::C_EN] && !wbDatW[tw_pkg::C_MS] && msSh_r
      |-> ##[1:1000] ($fell(sdaOe) && !sclOe);
  endproperty
  a_stop: assert property (p_stop)
    else $error("no stop after master select cleared");
endmodule : tw_ctrl_properties

bind tw_ctrl tw_ctrl_properties tw_ctrl_properties_i (.clk, .rst, .wbCyc,
  .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW, .wbDatR, .wbAck, .sclI, .sclO,
  .sclOe, .sdaI, .sdaO, .sdaOe, .irq);

// ---- dv/tw_slave_model.sv ----
module tw_slave_model (
  // bus lines
  input  wire logic  scl,
  input  wire logic  sda,
  output logic       sdaOe,
  // observation
  output logic [7:0] rxByte,
  output logic       mNack
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] ADDR = 7'h50;
  localparam logic [7:0] TXB  = 8'h96;
  logic [7:0] sh;
  // msb first, sampled on rising clock
  task automatic getByte;
    repeat (8) begin
      @(posedge scl);
      sh = {sh[6:0], sda};
    end
  endtask : getByte
  initial begin
    sdaOe = 1'b0;
    rxByte = 8'h00;
    mNack = 1'b0;
    forever begin
      @(negedge sda iff scl === 1'b1);
      fork
        @(posedge sda iff scl === 1'b1);
        begin
          getByte();
          if (sh[7:1] == ADDR) begin
            @(negedge scl);
            sdaOe = 1'b1;
            @(negedge scl);
            if (sh[0]) begin
              for (int i = 7; i >= 0; i--) begin
                sdaOe = !TXB[i];
                @(negedge scl);
              end
              sdaOe = 1'b0;
              @(posedge scl);
              mNack = sda;
            end else begin
              sdaOe = 1'b0;
              forever begin
                getByte();
                rxByte = sh;
                @(negedge scl);
                sdaOe = 1'b1;
                @(negedge scl);
                sdaOe = 1'b0;
              end
            end
          end
          wait (1'b0);
        end
      join_any
      // stop ends any byte in flight
      disable fork;
      sdaOe = 1'b0;
    end
  end
endmodule : tw_slave_model

// ---- src/tw_ctrl.sv ----
// Function
// - controller works only while the enable bit is one
// - interrupt enable bit masks or allows the interrupt request
// - master select zero to one makes a start and enters master mode; on a busy bus it records arbitration lost instead
// - master select one to zero makes a stop and returns to slave
// - receiver drives ack cycle from the ack response control bit
// - repeat start request works only as current master, reads zero
// - repeat start at a wrong moment records arbitration lost
// - transfer done flag set at byte end, low while in progress
// - data read in receive or write in transmit clears done flag
// - addressed flag set on own address or enabled general call
// - any control register write clears the addressed flag
// - busy set on start, cleared on stop, in any mode
// - arbitration lost set on loss, cleared by writing one
// - slave read/write flag shows r/w bit of calling address
// - pending flag set on byte end, match or loss; write one clears
// - received ack flag holds the ack sampled after each sent byte
// - data write in transmit starts sending, msb first
// - data read in master receive starts the next byte
// - transfer starts only when direction matches the access
// - data read in receive mode returns the last received byte
// - first byte after entering master mode is the address byte
// - general call enable decides if general call is recognised
//
// The register offsets and the Wishbone slave port were decided locally.
module tw_ctrl (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // wishbone slave
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatW,
  output logic      [31:0] wbDatR,
  output logic             wbAck,
  // two-wire bus pins
  input  wire logic        sclI,
  output logic             sclO,
  output logic             sclOe,
  input  wire logic        sdaI,
  output logic             sdaO,
  output logic             sdaOe,
  // interrupt
  output logic             irq
);

  // ==========================================================
  // state
  tw_pkg::tw_regs_t  r;
  tw_pkg::tw_regs_t  n;
  tw_pkg::tw_state_t goSt;
  logic [1:0]        goPh;
  logic              go;
  logic              sr;
  logic              sd;
  logic              rise;
  logic              fall;
  logic              startC;
  logic              stopC;
  logic              acc;
  logic              wr;
  logic              rd;
  logic              hold;
  logic              match;
  logic [7:0]        wd;

  assign sr     = r.sclS[1];
  assign sd     = r.sdaS[1];
  assign rise   = sr & !r.sclP;
  assign fall   = !sr & r.sclP;
  assign startC = sr & r.sclP & !sd & r.sdaP;
  assign stopC  = sr & r.sclP & sd & !r.sdaP;
  assign acc    = wbCyc & wbStb & !r.ackR;
  assign wr     = acc & wbWe & wbSel[0];
  assign rd     = acc & !wbWe;
  assign wd     = wbDatW[7:0];
  // released clock still held low elsewhere: wait (sync, stretch)
  assign hold   = !r.sclLow & !sr;
  assign match  = !r.msel & ((r.sSh[7:1] == r.sadr)
                | (r.gce & (r.sSh[7:1] == 7'h00)));

  // ==========================================================
  // next state
  always_comb begin
    n = r;
    go = 1'b0;
    goSt = tw_pkg::ST_IDLE;
    goPh = 2'd0;
    n.sclS = {r.sclS[0], sclI};
    n.sdaS = {r.sdaS[0], sdaI};
    n.sclP = sr;
    n.sdaP = sd;
    n.ackR = wbCyc & wbStb & !r.ackR;

    // ========================================================
    // register access
    if (acc) begin
      n.datR = tw_pkg::RST_VAL;
      case (wbAdr)
        tw_pkg::ADR_CTRL: begin
          if (wr) begin
            n.en   = wd[tw_pkg::C_EN];
            n.ie   = wd[tw_pkg::C_IE];
            n.msel = wd[tw_pkg::C_MS];
            n.txm  = wd[tw_pkg::C_TX];
            n.ackc = wd[tw_pkg::C_AK];
            n.aas  = 1'b0;
            if (wd[tw_pkg::C_MS] & !r.msel & wd[tw_pkg::C_EN]) begin
              // a start onto a busy bus is a lost arbitration
              if (r.busy) begin
                n.msel = 1'b0;
                n.arbitration_lost_flag = 1'b1;
                n.iif  = 1'b1;
              end else begin
                go = 1'b1;
                goSt = tw_pkg::ST_RS;
                goPh = 2'd2;
              end
            end else if (!wd[tw_pkg::C_MS] & r.msel) begin
              go = 1'b1;
              goSt = tw_pkg::ST_STOP;
            end else if (wd[tw_pkg::C_RS]) begin
              // only a master between bytes may repeat a start
              if (r.msel & (r.st == tw_pkg::ST_WAIT)) begin
                go = 1'b1;
                goSt = tw_pkg::ST_RS;
              end else begin
                n.arbitration_lost_flag = 1'b1;
                n.iif  = 1'b1;
              end
            end
          end
          // repeat start always reads as zero
          n.datR = {r.en, r.ie, r.msel, r.txm, r.ackc, 3'b000};
        end
        tw_pkg::ADR_STAT: begin
          if (wr & wd[tw_pkg::S_AL]) begin
            n.arbitration_lost_flag = 1'b0;
          end
          if (wr & wd[tw_pkg::S_IF]) begin
            n.iif = 1'b0;
          end
          n.datR = {r.transfer_done_flag, r.aas, r.busy, r.arbitration_lost_flag,
                    1'b0, r.slave_read_write_flag, r.iif, r.received_ack_flag};
        end
        tw_pkg::ADR_DATA: begin
          if (wr & r.txm) begin
            n.transfer_done_flag = 1'b0;
            if (r.msel & (r.st == tw_pkg::ST_WAIT)) begin
              go = 1'b1;
              goSt = tw_pkg::ST_BIT;
              n.sh = wd;
              n.bitN = 4'd0;
              n.mRx = 1'b0;
            end else if (r.sMine & r.slave_read_write_flag) begin
              n.sSh = wd;
              if (r.sStr) begin
                n.sStr = 1'b0;
                n.sSdaLow = !wd[7];
              end
            end
          end
          if (rd & !r.txm) begin
            n.transfer_done_flag = 1'b0;
            if (r.msel & (r.st == tw_pkg::ST_WAIT)) begin
              go = 1'b1;
              goSt = tw_pkg::ST_BIT;
              n.bitN = 4'd0;
              n.mRx = 1'b1;
            end else if (r.sStr & r.sMine & !r.slave_read_write_flag) begin
              n.sStr = 1'b0;
            end
          end
          // reads in transmit start nothing
          n.datR = r.rxd;
        end
        tw_pkg::ADR_SADR: begin
          if (wr) begin
            n.sadr = wd[7:1];
          end
          n.datR = {r.sadr, 1'b0};
        end
        tw_pkg::ADR_CTRL2: begin
          if (wr) begin
            n.gce = wd[tw_pkg::C2_GC];
          end
          n.datR = {r.gce, 7'h00};
        end
        default: n.datR = tw_pkg::RST_VAL;
      endcase
    end

    // ========================================================
    // master sequencer: four timed phases per step
    if ((r.st != tw_pkg::ST_IDLE) & (r.st != tw_pkg::ST_WAIT)) begin
      if (hold) begin
        n.tmr = tw_pkg::QTR;
      end else if (r.tmr != 8'h00) begin
        n.tmr = r.tmr - 8'h01;
      end else begin
        n.tmr = tw_pkg::QTR;
        n.ph = r.ph + 2'd1;
        case (r.st)
          tw_pkg::ST_RS: begin
            case (r.ph)
              2'd0: n.sdaLow = 1'b0;
              2'd1: n.sclLow = 1'b0;
              2'd2: n.sdaLow = 1'b1;
              default: begin
                n.sclLow = 1'b1;
                n.st = tw_pkg::ST_WAIT;
              end
            endcase
          end
          tw_pkg::ST_STOP: begin
            case (r.ph)
              2'd0: n.sclLow = 1'b1;
              2'd1: n.sdaLow = 1'b1;
              2'd2: n.sclLow = 1'b0;
              default: begin
                n.sdaLow = 1'b0;
                n.st = tw_pkg::ST_IDLE;
              end
            endcase
          end
          tw_pkg::ST_BIT: begin
            case (r.ph)
              2'd0: begin
                if (r.bitN == tw_pkg::ACK_BIT) begin
                  n.sdaLow = r.mRx & !r.ackc;
                end else begin
                  n.sdaLow = !r.mRx & !r.sh[7];
                end
              end
              2'd1: n.sclLow = 1'b0;
              2'd2: begin
                if (r.bitN == tw_pkg::ACK_BIT) begin
                  if (!r.mRx) begin
                    n.received_ack_flag = sd;
                  end
                end else begin
                  n.sh = {r.sh[6:0], sd};
                  // sent a one, line reads zero: another master won
                  if (!r.mRx & r.sh[7] & !sd) begin
                    n.msel = 1'b0;
                    n.arbitration_lost_flag = 1'b1;
                    n.iif = 1'b1;
                    n.sdaLow = 1'b0;
                    n.st = tw_pkg::ST_IDLE;
                  end
                end
              end
              default: begin
                n.sclLow = 1'b1;
                if (r.bitN == tw_pkg::ACK_BIT) begin
                  n.sdaLow = 1'b0;
                  n.transfer_done_flag = 1'b1;
                  n.iif = 1'b1;
                  n.st = tw_pkg::ST_WAIT;
                  if (r.mRx) begin
                    n.rxd = r.sh;
                  end
                end else begin
                  n.bitN = r.bitN + 4'd1;
                end
              end
            endcase
          end
          default: n.st = tw_pkg::ST_IDLE;
        endcase
      end
    end

    // ========================================================
    // bus watcher and slave side
    if (startC) begin
      n.busy = 1'b1;
      n.sAct = 1'b1;
      n.sAdr = 1'b1;
      n.sMine = 1'b0;
      // the start's own clock fall wraps this to zero
      n.sCnt = 4'hf;
      n.sSdaLow = 1'b0;
      n.sStr = 1'b0;
    end else if (stopC) begin
      n.busy = 1'b0;
      n.sAct = 1'b0;
      n.sMine = 1'b0;
      n.sSdaLow = 1'b0;
      n.sStr = 1'b0;
    end else if (r.sAct & rise) begin
      if (r.sCnt != tw_pkg::ACK_BIT) begin
        n.sSh = {r.sSh[6:0], sd};
      end else if (r.sMine & r.slave_read_write_flag & !r.sAdr) begin
        n.received_ack_flag = sd;
      end
    end else if (r.sAct & fall) begin
      case (r.sCnt)
        tw_pkg::LAST_BIT: begin
          n.sCnt = tw_pkg::ACK_BIT;
          n.sSdaLow = 1'b0;
          if (r.sAdr) begin
            if (match) begin
              n.sMine = 1'b1;
              n.aas = 1'b1;
              n.slave_read_write_flag = r.sSh[0];
              n.transfer_done_flag = 1'b1;
              n.iif = 1'b1;
              n.sSdaLow = 1'b1;
            end else begin
              n.sAct = 1'b0;
            end
          end else if (r.sMine & !r.slave_read_write_flag) begin
            n.rxd = r.sSh;
            n.transfer_done_flag = 1'b1;
            n.iif = 1'b1;
            n.sSdaLow = !r.ackc;
          end
        end
        tw_pkg::ACK_BIT: begin
          n.sCnt = 4'd0;
          n.sAdr = 1'b0;
          n.sSdaLow = 1'b0;
          if (r.sMine & r.slave_read_write_flag & !r.sAdr) begin
            n.transfer_done_flag = 1'b1;
            n.iif = 1'b1;
          end
          // a refused byte ends slave transmit: never stretch then
          if (r.sMine & (n.transfer_done_flag | (r.slave_read_write_flag & !r.sAdr))
              & !(r.slave_read_write_flag & !r.sAdr & r.received_ack_flag)) begin
            n.sStr = n.transfer_done_flag;
            n.sSdaLow = r.slave_read_write_flag & !n.transfer_done_flag & !r.sSh[7];
          end
        end
        default: begin
          n.sCnt = r.sCnt + 4'd1;
          if (r.sMine & r.slave_read_write_flag & !r.sAdr) begin
            n.sSdaLow = !r.sSh[7];
          end
        end
      endcase
    end

    // ========================================================
    // disabled controller lets go of everything
    if (!n.en) begin
      n.st = tw_pkg::ST_IDLE;
      n.msel = 1'b0;
      n.sclLow = 1'b0;
      n.sdaLow = 1'b0;
      n.sAct = 1'b0;
      n.sMine = 1'b0;
      n.sStr = 1'b0;
      n.sSdaLow = 1'b0;
      n.busy = 1'b0;
    end else if (go) begin
      n.st = goSt;
      n.ph = goPh;
      n.tmr = tw_pkg::QTR;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // outputs: open drain, only ever pull low
  assign wbDatR = {24'h000000, r.datR};
  assign wbAck  = r.ackR;
  assign sclO   = 1'b0;
  assign sdaO   = 1'b0;
  assign sclOe  = r.sclLow | r.sStr;
  assign sdaOe  = r.sdaLow | (r.sSdaLow & !r.msel);
  assign irq    = r.iif & r.ie;

endmodule : tw_ctrl

// ---- src/tw_pkg.sv ----
package tw_pkg;

  // ==========================================================
  // register map (byte addresses, one word each)
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_STAT  = 8'h04;
  localparam logic [7:0] ADR_DATA  = 8'h08;
  localparam logic [7:0] ADR_SADR  = 8'h0c;
  localparam logic [7:0] ADR_CTRL2 = 8'h10;

  // ==========================================================
  // control fields
  localparam int C_EN = 7;
  localparam int C_IE = 6;
  localparam int C_MS = 5;
  localparam int C_TX = 4;
  localparam int C_AK = 3;
  localparam int C_RS = 2;
  localparam int C2_GC = 7;

  // ==========================================================
  // status fields
  localparam int S_TC = 7;
  localparam int S_AS = 6;
  localparam int S_BY = 5;
  localparam int S_AL = 4;
  localparam int S_RW = 2;
  localparam int S_IF = 1;
  localparam int S_RK = 0;

  // ==========================================================
  // bus timing: one quarter of a 100 kbit/s bit time
  localparam int BIT_NS = 10000;
  localparam int CLK_NS = 20;
  localparam logic [7:0] QTR = 8'(BIT_NS / (4 * CLK_NS));
  localparam logic [7:0] RST_VAL = 8'h00;
  localparam logic [3:0] ACK_BIT = 4'd8;
  localparam logic [3:0] LAST_BIT = 4'd7;

  // ==========================================================
  // master sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RS   = 3'b001,
    ST_WAIT = 3'b011,
    ST_BIT  = 3'b010,
    ST_STOP = 3'b110
  } tw_state_t;

  typedef struct packed {
    logic [1:0] sclS;
    logic [1:0] sdaS;
    logic       sclP;
    logic       sdaP;
    logic       ackR;
    logic [7:0] datR;
    logic       en;
    logic       ie;
    logic       msel;
    logic       txm;
    logic       ackc;
    logic       transfer_done_flag;
    logic       aas;
    logic       busy;
    logic       arbitration_lost_flag;
    logic       slave_read_write_flag;
    logic       iif;
    logic       received_ack_flag;
    logic [7:0] rxd;
    logic [6:0] sadr;
    logic       gce;
    tw_state_t  st;
    logic [1:0] ph;
    logic [7:0] tmr;
    logic [3:0] bitN;
    logic       mRx;
    logic [7:0] sh;
    logic       sclLow;
    logic       sdaLow;
    logic       sAct;
    logic       sAdr;
    logic       sMine;
    logic       sStr;
    logic       sSdaLow;
    logic [3:0] sCnt;
    logic [7:0] sSh;
  } tw_regs_t;

endpackage : tw_pkg
